// ==== src/icr_pkg.sv ====
/*
 * Constants and types for the input calibration register bank.
 * Assumes a 16-bit word bank at word offsets 0x16 to 0x23.
 */
package icr_pkg;
   // Calibration values are fractions of the total, times 65536
   typedef logic [15:0] icr_word_t;

   localparam int NUM_REGS = 14;
   localparam logic [7:0] OFF_BASE = 8'h16;
   localparam logic [7:0] OFF_MAN_HSTART = 8'h16;
   localparam logic [7:0] OFF_MAN_VSTART = 8'h17;
   localparam logic [7:0] OFF_HSYNC_LO = 8'h18;
   localparam logic [7:0] OFF_HSYNC_HI = 8'h19;
   localparam logic [7:0] OFF_VSYNC_LO = 8'h1a;
   localparam logic [7:0] OFF_VSYNC_HI = 8'h1b;
   localparam logic [7:0] OFF_HPOS_LO = 8'h1c;
   localparam logic [7:0] OFF_HPOS_HI = 8'h1d;
   localparam logic [7:0] OFF_VPOS_LO = 8'h1e;
   localparam logic [7:0] OFF_VPOS_HI = 8'h1f;
   localparam logic [7:0] OFF_GPO = 8'h20;
   localparam logic [7:0] OFF_IHC_COPY = 8'h21;
   localparam logic [7:0] OFF_IVC_COPY = 8'h22;
   localparam logic [7:0] OFF_HACT = 8'h23;

   // Word indices inside the bank
   localparam logic [3:0] IDX_MAN_HSTART = 4'h0;
   localparam logic [3:0] IDX_MAN_VSTART = 4'h1;
   localparam logic [3:0] IDX_HSYNC_LO = 4'h2;
   localparam logic [3:0] IDX_HSYNC_HI = 4'h3;
   localparam logic [3:0] IDX_VSYNC_LO = 4'h4;
   localparam logic [3:0] IDX_VSYNC_HI = 4'h5;
   localparam logic [3:0] IDX_HPOS_LO = 4'h6;
   localparam logic [3:0] IDX_HPOS_HI = 4'h7;
   localparam logic [3:0] IDX_VPOS_LO = 4'h8;
   localparam logic [3:0] IDX_VPOS_HI = 4'h9;
   localparam logic [3:0] IDX_GPO = 4'ha;
   localparam logic [3:0] IDX_IHC_COPY = 4'hb;
   localparam logic [3:0] IDX_IVC_COPY = 4'hc;
   localparam logic [3:0] IDX_HACT = 4'hd;

   localparam icr_word_t RST_MAN_HSTART = 16'h2666;
   localparam icr_word_t RST_MAN_VSTART = 16'h0666;
   localparam icr_word_t RST_OTHER = 16'h0000;

   // Reset value of a bank word by index
   function automatic icr_word_t resetValue(input int idx);
      if (idx == int'(IDX_MAN_HSTART)) begin
         return RST_MAN_HSTART;
      end
      if (idx == int'(IDX_MAN_VSTART)) begin
         return RST_MAN_VSTART;
      end
      return RST_OTHER;
   endfunction
endpackage

// ==== src/icr_reg_file.sv ====
/*
 * Storage for the calibration bank: one flop word per register with
 * per-word write enables and a registered read port.
 * Assumes the caller resolves write priority before the enables.
 */
`timescale 1ns/100ps
module icr_reg_file (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [icr_pkg::NUM_REGS-1:0] wrEn,
   input wire logic [icr_pkg::NUM_REGS*16-1:0] wrData,
   input wire logic rdEn,
   input wire logic [3:0] rdIdx,
   output logic [15:0] rdData,
   output logic [icr_pkg::NUM_REGS*16-1:0] words
);
   genvar i;

   // Each word loads its own reset constant
   generate
      for (i = 0; i < icr_pkg::NUM_REGS; i++) begin : gWord
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               words[i*16 +: 16] <= icr_pkg::resetValue(i);
            end else if (wrEn[i]) begin
               words[i*16 +: 16] <= wrData[i*16 +: 16];
            end
         end
      end
   endgenerate

   // Registered read; reading has no side effect on the words
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData <= 16'h0000;
      end else if (rdEn) begin
         // An index past the last word stands for an unmapped address
         if (int'(rdIdx) < icr_pkg::NUM_REGS) begin
            rdData <= words[rdIdx*16 +: 16];
         end else begin
            rdData <= 16'h0000;
         end
      end
   end
endmodule

// ==== src/input_calibration_regs.sv ====
/*
 * Input calibration register bank: manual start-of-video selection,
 * sync and position limit clamping, output shadow, count copies and
 * current active width/height.
 * Assumes all inputs are synchronous to clk; host read data arrive one
 * cycle after the read strobe.
 */
// Notes on behaviour
// - Manual mode uses stored horizontal start
// - Manual mode uses stored vertical start
// - Manual mode exactly when calibration disabled
// - Values are 16-bit fractions times 65536
// - Horizontal sync start kept within limits
// - Vertical sync start kept within limits
// - Horizontal limits: pan in zoom, else offset
// - Vertical limits: pan in zoom, else offset
// - Output shadow; bit 0 from micro-controller
// - Micro-controller keeps input count copies
// - Horizontal active: default or measured width
// - Vertical active falls back to default
`timescale 1ns/100ps
module input_calibration_regs (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [7:0] hostAddr,
   input wire logic [15:0] hostWData,
   output logic [15:0] hostRData,
   output logic hostRValid,
   input wire logic ucGpoWrite,
   input wire logic ucGpoBit0,
   input wire logic autoCalDisable,
   input wire logic [15:0] autoHorizBegin,
   input wire logic [15:0] autoVertBegin,
   output logic [15:0] horizVideoBeginSel,
   output logic [15:0] vertVideoBeginSel,
   input wire logic countStrobe,
   input wire logic [15:0] inputHorizCount,
   input wire logic [15:0] inputVertCount,
   input wire logic horizMeasStrobe,
   input wire logic horizMeasValid,
   input wire logic [15:0] horizVideoBegin,
   input wire logic [15:0] horizVideoEnd,
   input wire logic [15:0] defaultHorizActive,
   input wire logic vertMeasValid,
   input wire logic [15:0] measVertActive,
   input wire logic [15:0] defaultVertActive,
   output logic [15:0] vertActiveHeight,
   input wire logic [15:0] horizSyncStartReq,
   input wire logic [15:0] vertSyncStartReq,
   output logic [15:0] horizSyncStart,
   output logic [15:0] vertSyncStart,
   input wire logic zoomEnable,
   input wire logic [15:0] horizPositionReq,
   input wire logic [15:0] vertPositionReq,
   output logic [15:0] horizPosition,
   output logic [15:0] vertPosition,
   output logic positionIsPan,
   output logic [15:0] generalOutput
);
   logic [icr_pkg::NUM_REGS-1:0] wrEn;
   logic [icr_pkg::NUM_REGS*16-1:0] wrData;
   logic [icr_pkg::NUM_REGS*16-1:0] words;
   logic hostHit;
   logic [3:0] hostIdx;
   icr_pkg::icr_word_t horizActiveCalc;

   // Bank word by index
   function automatic icr_pkg::icr_word_t word(input logic [3:0] idx,
         input logic [icr_pkg::NUM_REGS*16-1:0] w);
      return w[idx*16 +: 16];
   endfunction

   // Saturating range limit; an inverted range yields the lower limit
   function automatic icr_pkg::icr_word_t clampTo(input icr_pkg::icr_word_t v,
         input icr_pkg::icr_word_t lo, input icr_pkg::icr_word_t hi);
      if (v < lo || lo > hi) begin
         return lo;
      end
      if (v > hi) begin
         return hi;
      end
      return v;
   endfunction

   // Address decode onto the bank
   assign hostHit = (hostAddr >= icr_pkg::OFF_BASE) && (hostAddr <= icr_pkg::OFF_HACT);
   assign hostIdx = 4'(hostAddr - icr_pkg::OFF_BASE);

   // Width from measured edges, unsigned fraction of the total
   assign horizActiveCalc = horizVideoEnd - horizVideoBegin;

   // Write priority: internal updates win over a host write to the same word
   always_comb begin
      wrEn = '0;
      wrData = words;
      if (hostWrite && hostHit) begin
         wrEn[hostIdx] = 1'b1;
         wrData[hostIdx*16 +: 16] = hostWData;
         if (hostIdx == icr_pkg::IDX_GPO) begin
            // Host owns only the upper bits of the shadow
            wrData[icr_pkg::IDX_GPO*16] = words[icr_pkg::IDX_GPO*16];
         end
      end
      if (ucGpoWrite) begin
         wrEn[icr_pkg::IDX_GPO] = 1'b1;
         wrData[icr_pkg::IDX_GPO*16] = ucGpoBit0;
      end
      if (countStrobe) begin
         wrEn[icr_pkg::IDX_IHC_COPY] = 1'b1;
         wrEn[icr_pkg::IDX_IVC_COPY] = 1'b1;
         wrData[icr_pkg::IDX_IHC_COPY*16 +: 16] = inputHorizCount;
         wrData[icr_pkg::IDX_IVC_COPY*16 +: 16] = inputVertCount;
      end
      if (horizMeasStrobe) begin
         wrEn[icr_pkg::IDX_HACT] = 1'b1;
         // An end at or before the start is no valid measurement
         if (horizMeasValid && horizVideoEnd > horizVideoBegin) begin
            wrData[icr_pkg::IDX_HACT*16 +: 16] = horizActiveCalc;
         end else begin
            wrData[icr_pkg::IDX_HACT*16 +: 16] = defaultHorizActive;
         end
      end
   end

   // Unmapped reads use an index past the last word, which reads zero;
   // this keeps the read data straight out of the file's register
   icr_reg_file uFile (
      .clk(clk),
      .reset_n(reset_n),
      .wrEn(wrEn),
      .wrData(wrData),
      .rdEn(hostRead),
      .rdIdx(hostHit ? hostIdx : 4'hf),
      .rdData(hostRData),
      .words(words)
   );

   // Read answer one cycle later, for mapped and unmapped addresses alike
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hostRValid <= 1'b0;
      end else begin
         hostRValid <= hostRead;
      end
   end

   // Start-of-video source chosen by the calibration-disable bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         horizVideoBeginSel <= icr_pkg::RST_MAN_HSTART;
         vertVideoBeginSel <= icr_pkg::RST_MAN_VSTART;
      end else if (autoCalDisable) begin
         horizVideoBeginSel <= word(icr_pkg::IDX_MAN_HSTART, words);
         vertVideoBeginSel <= word(icr_pkg::IDX_MAN_VSTART, words);
      end else begin
         horizVideoBeginSel <= autoHorizBegin;
         vertVideoBeginSel <= autoVertBegin;
      end
   end

   // Sync start settings held inside the stored limit range, the same in every mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         horizSyncStart <= icr_pkg::RST_OTHER;
         vertSyncStart <= icr_pkg::RST_OTHER;
      end else begin
         horizSyncStart <= clampTo(horizSyncStartReq, word(icr_pkg::IDX_HSYNC_LO, words),
            word(icr_pkg::IDX_HSYNC_HI, words));
         vertSyncStart <= clampTo(vertSyncStartReq, word(icr_pkg::IDX_VSYNC_LO, words),
            word(icr_pkg::IDX_VSYNC_HI, words));
      end
   end

   // Same limit words serve pan in zoom and offset otherwise
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         horizPosition <= icr_pkg::RST_OTHER;
         vertPosition <= icr_pkg::RST_OTHER;
         positionIsPan <= 1'b0;
      end else begin
         positionIsPan <= zoomEnable;
         horizPosition <= clampTo(horizPositionReq, word(icr_pkg::IDX_HPOS_LO, words),
            word(icr_pkg::IDX_HPOS_HI, words));
         vertPosition <= clampTo(vertPositionReq, word(icr_pkg::IDX_VPOS_LO, words),
            word(icr_pkg::IDX_VPOS_HI, words));
      end
   end

   // Vertical active height with default fallback
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vertActiveHeight <= icr_pkg::RST_OTHER;
      end else begin
         vertActiveHeight <= vertMeasValid ? measVertActive : defaultVertActive;
      end
   end

   assign generalOutput = word(icr_pkg::IDX_GPO, words);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Steps of the write-then-read check on one limit word
   sequence sHostWriteLimit;
      hostWrite && hostAddr == icr_pkg::OFF_VSYNC_HI;
   endsequence
   sequence sHostReadLimit;
      hostRead && !hostWrite && hostAddr == icr_pkg::OFF_VSYNC_HI;
   endsequence
   // Host write to a start or limit word; no internal strobe touches those
   sequence sPlainHostWrite;
      hostWrite && hostHit && hostIdx < icr_pkg::IDX_GPO;
   endsequence
   // Host write to the shadow with no micro-controller write beside it
   sequence sHostShadowWrite;
      hostWrite && hostAddr == icr_pkg::OFF_GPO && !ucGpoWrite;
   endsequence
   // Width strobe with a usable measurement, and without one
   sequence sHactMeasured;
      horizMeasStrobe && horizMeasValid && horizVideoEnd > horizVideoBegin;
   endsequence
   sequence sHactFallback;
      horizMeasStrobe && !(horizMeasValid && horizVideoEnd > horizVideoBegin);
   endsequence

   // Start-of-video selection follows the mode bit one cycle later
   a_manual_hstart: assert property (autoCalDisable |=>
      horizVideoBeginSel == $past(words[0 +: 16]))
      else $error("manual horizontal start not applied");
   a_manual_vstart: assert property (autoCalDisable |=>
      vertVideoBeginSel == $past(words[16 +: 16]))
      else $error("manual vertical start not applied");
   a_auto_start: assert property (!autoCalDisable |=>
      horizVideoBeginSel == $past(autoHorizBegin) && vertVideoBeginSel == $past(autoVertBegin))
      else $error("automatic start values not applied");

   // Limits; a well-formed range holds the result inside it
   a_hsync_range: assert property (words[32 +: 16] <= words[48 +: 16] |=>
      horizSyncStart >= $past(words[32 +: 16]) && horizSyncStart <= $past(words[48 +: 16]))
      else $error("horizontal sync start out of range");
   a_vsync_range: assert property (words[64 +: 16] <= words[80 +: 16] |=>
      vertSyncStart >= $past(words[64 +: 16]) && vertSyncStart <= $past(words[80 +: 16]))
      else $error("vertical sync start out of range");
   a_hpos_range: assert property (words[96 +: 16] <= words[112 +: 16] |=>
      horizPosition >= $past(words[96 +: 16]) && horizPosition <= $past(words[112 +: 16]))
      else $error("horizontal position out of range");
   a_vpos_range: assert property (words[128 +: 16] <= words[144 +: 16] |=>
      vertPosition >= $past(words[128 +: 16]) && vertPosition <= $past(words[144 +: 16]))
      else $error("vertical position out of range");
   // An inverted range collapses to its lower limit; position mode follows zoom one cycle later
   a_hsync_inverted: assert property (words[32 +: 16] > words[48 +: 16] |=>
      horizSyncStart == $past(words[32 +: 16]))
      else $error("inverted horizontal sync range not at lower limit");
   a_vsync_inverted: assert property (words[64 +: 16] > words[80 +: 16] |=>
      vertSyncStart == $past(words[64 +: 16]))
      else $error("inverted vertical sync range not at lower limit");
   a_hpos_inverted: assert property (words[96 +: 16] > words[112 +: 16] |=>
      horizPosition == $past(words[96 +: 16]))
      else $error("inverted horizontal position range not at lower limit");
   a_pos_mode: assert property (1'b1 |=>
      positionIsPan == $past(zoomEnable))
      else $error("position mode does not follow zoom");

   // Shadow bit 0 belongs to the micro-controller, the rest to the host
   a_gpo_bit_owner: assert property (ucGpoWrite |=>
      generalOutput[0] == $past(ucGpoBit0))
      else $error("output shadow bit 0 not from micro-controller");
   a_gpo_host_keep: assert property (sHostShadowWrite |=>
      generalOutput == {$past(hostWData[15:1]), $past(generalOutput[0])})
      else $error("host write to output shadow changed bit 0");

   // Copies and horizontal active width written by internal strobes; vertical active height follows its valid bit
   a_count_copy: assert property (countStrobe |=>
      words[176 +: 16] == $past(inputHorizCount) && words[192 +: 16] == $past(inputVertCount))
      else $error("input count copies not stored");
   a_hact_measured: assert property (sHactMeasured |=>
      words[208 +: 16] == 16'($past(horizVideoEnd) - $past(horizVideoBegin)))
      else $error("horizontal active width not measured");
   a_hact_default: assert property (sHactFallback |=>
      words[208 +: 16] == $past(defaultHorizActive))
      else $error("horizontal active default not used");
   a_vact_fallback: assert property (!vertMeasValid |=>
      vertActiveHeight == $past(defaultVertActive))
      else $error("vertical active did not fall back");
   a_vact_measured: assert property (vertMeasValid |=>
      vertActiveHeight == $past(measVertActive))
      else $error("vertical active measurement not used");

   // Host port: answer timing, read-back and no read side effect
   a_read_back: assert property (sHostWriteLimit ##1 sHostReadLimit |=>
      hostRValid && hostRData == $past(hostWData, 2))
      else $error("read did not return written value");
   a_plain_write: assert property (sPlainHostWrite |=>
      word($past(hostIdx), words) == $past(hostWData))
      else $error("host write did not land");
   a_unmapped_zero: assert property (hostRead && !hostHit |=>
      hostRValid && hostRData == 16'h0000)
      else $error("unmapped read not zero");
   a_rvalid_pulse: assert property (1'b1 |=>
      hostRValid == $past(hostRead))
      else $error("read valid not one cycle after strobe");
   a_read_no_effect: assert property (hostRead && !hostWrite && !ucGpoWrite && !countStrobe
      && !horizMeasStrobe |=> $stable(words))
      else $error("read changed a stored word");
endmodule

// ==== sim/icr_uc_model.sv ====
/*
 * Micro-controller side model: turns bench requests into one-cycle
 * update strobes for the bank.
 * Assumes single-cycle request pulses synchronous to clk.
 */
`timescale 1ns/100ps
module icr_uc_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [2:0] req,
   output logic ucGpoWrite,
   output logic countStrobe,
   output logic horizMeasStrobe
);
   // One cycle late, like firmware reacting to an event
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ucGpoWrite <= 1'h0;
         countStrobe <= 1'h0;
         horizMeasStrobe <= 1'h0;
      end else begin
         ucGpoWrite <= req[0];
         countStrobe <= req[1];
         horizMeasStrobe <= req[2];
      end
   end
endmodule

// ==== sim/input_calibration_regs_tb.sv ====
/*
 * Self-checking bench for the calibration bank: reset values, host
 * access, start selection, clamping and micro-controller updates.
 * Assumes the package and the micro-controller model are compiled first.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin numErrors++; \
$display("[ERR] %s exp %h got %h", n, e, g); end end
module input_calibration_regs_tb;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic hostWrite = 1'h0, hostRead = 1'h0, ucGpoBit0 = 1'h0, autoCalDisable = 1'h0;
   logic horizMeasValid = 1'h0, vertMeasValid = 1'h0, zoomEnable = 1'h0;
   logic [2:0] ucReq = 3'h0;
   logic [7:0] hostAddr = 8'h00;
   logic [15:0] hostWData = 16'h0000, autoHorizBegin = 16'h0000, autoVertBegin = 16'h0000;
   logic [15:0] inputHorizCount = 16'h0000, inputVertCount = 16'h0000;
   logic [15:0] horizVideoBegin = 16'h0000, horizVideoEnd = 16'h0000;
   logic [15:0] defaultHorizActive = 16'h0000, measVertActive = 16'h0000;
   logic [15:0] defaultVertActive = 16'h0000, horizSyncStartReq = 16'h0000;
   logic [15:0] vertSyncStartReq = 16'h0000, horizPositionReq = 16'h0000;
   logic [15:0] vertPositionReq = 16'h0000;
   logic [15:0] hostRData, horizVideoBeginSel, vertVideoBeginSel, vertActiveHeight;
   logic [15:0] horizSyncStart, vertSyncStart, horizPosition, vertPosition, generalOutput;
   logic hostRValid, positionIsPan, ucGpoWrite, countStrobe, horizMeasStrobe;
   icr_pkg::icr_word_t mem [14];
   integer seed = 32'ha8d5;
   int numErrors = 0;
   int checked = 0;

   // 200 MHz
   always #2.5 clk = ~clk;

   input_calibration_regs i_dut (
      .clk(clk), .reset_n(reset_n), .hostWrite(hostWrite), .hostRead(hostRead),
      .hostAddr(hostAddr), .hostWData(hostWData), .hostRData(hostRData),
      .hostRValid(hostRValid), .ucGpoWrite(ucGpoWrite), .ucGpoBit0(ucGpoBit0),
      .autoCalDisable(autoCalDisable), .autoHorizBegin(autoHorizBegin),
      .autoVertBegin(autoVertBegin), .horizVideoBeginSel(horizVideoBeginSel),
      .vertVideoBeginSel(vertVideoBeginSel), .countStrobe(countStrobe),
      .inputHorizCount(inputHorizCount), .inputVertCount(inputVertCount),
      .horizMeasStrobe(horizMeasStrobe), .horizMeasValid(horizMeasValid),
      .horizVideoBegin(horizVideoBegin), .horizVideoEnd(horizVideoEnd),
      .defaultHorizActive(defaultHorizActive), .vertMeasValid(vertMeasValid),
      .measVertActive(measVertActive), .defaultVertActive(defaultVertActive),
      .vertActiveHeight(vertActiveHeight), .horizSyncStartReq(horizSyncStartReq),
      .vertSyncStartReq(vertSyncStartReq), .horizSyncStart(horizSyncStart),
      .vertSyncStart(vertSyncStart), .zoomEnable(zoomEnable),
      .horizPositionReq(horizPositionReq), .vertPositionReq(vertPositionReq),
      .horizPosition(horizPosition), .vertPosition(vertPosition),
      .positionIsPan(positionIsPan), .generalOutput(generalOutput)
   );

   icr_uc_model i_uc (
      .clk(clk), .reset_n(reset_n), .req(ucReq), .ucGpoWrite(ucGpoWrite),
      .countStrobe(countStrobe), .horizMeasStrobe(horizMeasStrobe)
   );

   // Inverted range falls back to the lower limit
   function automatic logic [15:0] clampV(logic [15:0] v, logic [15:0] lo, logic [15:0] hi);
      if (v < lo || lo > hi) return lo;
      if (v > hi) return hi;
      return v;
   endfunction

   // Measured width only when valid and not degenerate
   function automatic logic [15:0] hactV(logic vld, logic [15:0] b, logic [15:0] e,
      logic [15:0] d);
      return (vld && e > b) ? e - b : d;
   endfunction

   // Host write into the expected image; shadow bit 0 is not the host's
   function automatic void upd(logic [7:0] a, logic [15:0] d);
      if (a >= 8'h16 && a <= 8'h23) begin
         mem[a - 8'h16] = (a == 8'h20) ? {d[15:1], mem[10][0]} : d;
      end
   endfunction

   function automatic logic [15:0] expW(logic [7:0] a);
      return (a >= 8'h16 && a <= 8'h23) ? mem[a - 8'h16] : 16'h0000;
   endfunction

   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge clk);
      hostWrite <= 1'h1;
      hostAddr <= a;
      hostWData <= d;
      @(posedge clk);
      hostWrite <= 1'h0;
      upd(a, d);
   endtask

   // Strobe taken at the second edge; answer stands for the cycle after
   task automatic rd(logic [7:0] a, logic [15:0] e);
      @(posedge clk);
      hostRead <= 1'h1;
      hostAddr <= a;
      @(posedge clk);
      hostRead <= 1'h0;
      #1;
      `CHK("hostRValid", 1'h1, hostRValid)
      `CHK("hostRData", e, hostRData)
   endtask

   // Bank image after reset, then every word read back
   task automatic chkReset();
      foreach (mem[i]) mem[i] = 16'h0000;
      mem[0] = 16'h2666;
      mem[1] = 16'h0666;
      for (int i = 0; i < 14; i++) rd(8'h16 + 8'(i), mem[i]);
   endtask

   task automatic conclude();
      if (numErrors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      logic [15:0] b, e;
      logic [7:0] a;
      repeat (3) @(posedge clk);
      `CHK("hSelRst", 16'h2666, horizVideoBeginSel)
      `CHK("vSelRst", 16'h0666, vertVideoBeginSel)
      reset_n <= 1'h1;
      chkReset();
      // Micro-controller updates: shadow bit 0, count copies, active width
      for (int k = 0; k < 8; k++) begin
         b = 16'($random(seed));
         e = k[2] ? 16'($random(seed)) : b;
         @(posedge clk);
         ucGpoBit0 <= k[0];
         inputHorizCount <= 16'($random(seed));
         inputVertCount <= 16'($random(seed));
         horizMeasValid <= k[1];
         horizVideoBegin <= b;
         horizVideoEnd <= e;
         defaultHorizActive <= 16'($random(seed));
         ucReq <= 3'h7;
         @(posedge clk);
         ucReq <= 3'h0;
         tick(2);
         mem[10][0] = k[0];
         mem[11] = inputHorizCount;
         mem[12] = inputVertCount;
         mem[13] = hactV(k[1], b, e, defaultHorizActive);
         for (int j = 10; j < 14; j++) rd(8'h16 + 8'(j), mem[j]);
         `CHK("gpo", mem[10], generalOutput)
      end
      // Host traffic over the map and one word either side of it
      for (int k = 0; k < 40; k++) begin
         a = 8'h15 + 8'($random(seed) & 32'h0f);
         wr(a, 16'($random(seed)));
         rd(a, expW(a));
      end
      // Limits, zoom meaning, start selection and vertical fallback
      for (int k = 0; k < 16; k++) begin
         for (int j = 0; j < 8; j++) wr(8'h18 + 8'(j), 16'($random(seed)));
         @(posedge clk);
         zoomEnable <= k[0];
         vertMeasValid <= k[1];
         autoCalDisable <= k[3];
         horizSyncStartReq <= k[1] ? mem[2] : 16'($random(seed));
         vertSyncStartReq <= 16'($random(seed));
         horizPositionReq <= k[2] ? mem[7] : 16'($random(seed));
         vertPositionReq <= 16'($random(seed));
         measVertActive <= 16'($random(seed));
         defaultVertActive <= 16'($random(seed));
         autoHorizBegin <= 16'($random(seed));
         autoVertBegin <= 16'($random(seed));
         tick(2);
         `CHK("hSync", clampV(horizSyncStartReq, mem[2], mem[3]), horizSyncStart)
         `CHK("vSync", clampV(vertSyncStartReq, mem[4], mem[5]), vertSyncStart)
         `CHK("hPos", clampV(horizPositionReq, mem[6], mem[7]), horizPosition)
         `CHK("vPos", clampV(vertPositionReq, mem[8], mem[9]), vertPosition)
         `CHK("pan", k[0], positionIsPan)
         `CHK("vAct", k[1] ? measVertActive : defaultVertActive, vertActiveHeight)
         `CHK("hSel", k[3] ? mem[0] : autoHorizBegin, horizVideoBeginSel)
         `CHK("vSel", k[3] ? mem[1] : autoVertBegin, vertVideoBeginSel)
      end
      // Second reset in mid-run must restore every word
      @(posedge clk);
      reset_n <= 1'h0;
      tick(2);
      `CHK("gpoMid", 16'h0000, generalOutput)
      `CHK("panMid", 1'h0, positionIsPan)
      @(posedge clk);
      reset_n <= 1'h1;
      chkReset();
      // Calibration still disabled, so the restored manual words apply
      `CHK("hSelEnd", 16'h2666, horizVideoBeginSel)
      `CHK("vSelEnd", 16'h0666, vertVideoBeginSel)
      conclude();
   end

   // Far beyond the roughly 620 cycles the sequence needs
   initial begin
      #(20000 * 5);
      numErrors++;
      conclude();
   end
endmodule
